// *** tb/scbc_seq_model.sv ***
`timescale 1ns/1ps
// random instruction sequencer feeding the datapath
module scbc_seq_model (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // requests
   output logic o_cmp_cond,
   output logic o_conv_cond,
   output logic o_missing,
   // operands
   output logic [15:0] o_a_lo,
   output logic [15:0] o_a_hi,
   output logic [15:0] o_b_lo,
   output logic [15:0] o_b_hi,
   output logic [15:0] o_src
);
   integer seed = 32'h3d491ea0;
   logic [7:0] k;
   logic [31:0] a;
   logic [15:0] d;
   initial {o_cmp_cond, o_conv_cond, o_missing, o_src} = '0;
   always @(posedge i_ref_clk) begin
      k = 8'($random(seed));
      a = $random(seed);
      d = 16'($random(seed));
      o_cmp_cond <= k[0] & ~i_rst;
      o_conv_cond <= k[1] & ~i_rst;
      o_missing <= k[3:2] == 2'h0;
      // both words of an operand come as one unit
      {o_a_hi, o_a_lo} <= a;
      {o_b_hi, o_b_lo} <= k[4] ? a : (k[5] ? a - 32'h1 : $random(seed));
      case (k[7:6])
         2'h0: o_src <= {4'({$random(seed)} % 10),
            4'({$random(seed)} % 10), 4'h1, 4'h9};
         2'h1: o_src <= d;
         2'h2: o_src <= 16'h0000;
         default: o_src <= 16'h9999;
      endcase
   end
endmodule // scbc_seq_model

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic cc, vc, miss, ab, mt, bl, ft, wr;
   logic [15:0] alo, ahi, blo, bhi, src, res;
   logic e_ab = 1'b0, e_mt = 1'b0, e_bl = 1'b0, e_ft = 1'b0, e_wr = 1'b0;
   logic [15:0] e_res = '0;
   logic [16:0] r;
   int fail_count = 0;
   int n_tests = 0;
   always #2.5 i_ref_clk = ~i_ref_clk;
   scbc_seq_model seq_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
      .o_cmp_cond(cc), .o_conv_cond(vc), .o_missing(miss), .o_a_lo(alo),
      .o_a_hi(ahi), .o_b_lo(blo), .o_b_hi(bhi), .o_src(src));
   scbc_top dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cmp_cond(cc),
      .i_first_operand_lo(alo), .i_first_operand_hi(ahi),
      .i_second_operand_lo(blo), .i_second_operand_hi(bhi),
      .i_conv_cond(vc), .i_conv_src(src), .i_operand_missing(miss),
      .o_above_flag(ab), .o_match_flag(mt), .o_below_flag(bl),
      .o_fault_flag(ft), .o_conv_result(res), .o_conv_wr(wr));
   // bit 16 flags a bad digit
   function automatic logic [16:0] bcd_val(input logic [15:0] s);
      logic [16:0] v;
      v = '0;
      for (int i = 3; i >= 0; i--) begin
         v[16] = v[16] | (s[4*i+:4] > 4'h9);
         v[15:0] = v[15:0] * 16'h000a + 16'(s[4*i+:4]);
      end
      return v;
   endfunction
   task check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task end_sim;
      if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // reference model, sees the same pre-edge inputs as the design
   always @(posedge i_ref_clk) begin
      r = bcd_val(src);
      e_wr = 1'b0;
      if (i_rst) begin
         {e_ab, e_mt, e_bl, e_ft, e_res} = '0;
      end else if (cc) begin
         if (miss) e_ft = 1'b1;
         else {e_ab, e_mt, e_bl, e_ft} = {$signed({ahi, alo}) >
            $signed({bhi, blo}), {ahi, alo} == {bhi, blo},
            $signed({ahi, alo}) < $signed({bhi, blo}), 1'b0};
      end else if (vc) begin
         if (miss || r[16]) e_ft = 1'b1;
         else {e_res, e_wr, e_mt, e_ft} = {r[15:0], 1'b1,
            r[15:0] == 16'h0000, 1'b0};
      end
   end
   initial begin
      repeat (6) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      repeat (3000) begin
         @(negedge i_ref_clk);
         check({13'h0, ab, mt, bl}, {13'h0, e_ab, e_mt, e_bl});
         check({15'h0, ab | bl}, {15'h0, e_ab | e_bl});
         check({15'h0, ft}, {15'h0, e_ft});
         check(res, e_res);
         check({15'h0, wr}, {15'h0, e_wr});
         check({15'h0, mt}, {15'h0, e_mt});
      end
      end_sim;
   end
endmodule // tb

// *** verilog/scbc_bcd_conv.sv ***
`timescale 1ns/1ps
// combinational four-digit decimal to binary
module scbc_bcd_conv #(
   parameter int DIGITS = 4
) (
   // source
   input wire logic [4*DIGITS-1:0] i_bcd,
   // result
   output logic [4*DIGITS-1:0] o_bin,
   output logic o_bad_digit
);
   logic [DIGITS-1:0] bad;
   logic [4*DIGITS+3:0] acc [0:DIGITS];
   assign acc[0] = '0;
   genvar g;
   generate
      for (g = 0; g < DIGITS; g++) begin : g_dig
         logic [3:0] d;
         assign d = i_bcd[4*(DIGITS-1-g) +: 4];
         assign bad[g] = d > 4'h9;
         assign acc[g+1] = (4*DIGITS+4)'(acc[g] * 10 + d);
      end
   endgenerate
   assign o_bin = acc[DIGITS][4*DIGITS-1:0];
   assign o_bad_digit = |bad;
endmodule // scbc_bcd_conv

// *** verilog/scbc_map.svh ***
`ifndef SCBC_MAP_SVH
`define SCBC_MAP_SVH
`define SCBC_ABOVE_BIT 25505
`define SCBC_MATCH_BIT 25506
`define SCBC_BELOW_BIT 25507
`define SCBC_FLAG_RST 1'b0
`define SCBC_RESULT_RST 16'h0000
`define SCBC_LATENCY 1
`endif

// *** verilog/scbc_pkg.sv ***
package scbc_pkg;
   typedef enum logic [2:0] {
      SCBC_OP_NONE = 3'b001,
      SCBC_OP_CMP = 3'b010,
      SCBC_OP_CONV = 3'b100
   } scbc_op_t;
endpackage

// *** verilog/scbc_top.sv ***
`timescale 1ns/1ps
`include "scbc_map.svh"
module scbc_top #(
   parameter int WORD = 16
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // compare request
   input wire logic i_cmp_cond,
   input wire logic [WORD-1:0] i_first_operand_lo,
   input wire logic [WORD-1:0] i_first_operand_hi,
   input wire logic [WORD-1:0] i_second_operand_lo,
   input wire logic [WORD-1:0] i_second_operand_hi,
   // conversion request
   input wire logic i_conv_cond,
   input wire logic [WORD-1:0] i_conv_src,
   // indirect operand missing
   input wire logic i_operand_missing,
   // relay flags
   output logic o_above_flag,
   output logic o_match_flag,
   output logic o_below_flag,
   output logic o_fault_flag,
   // conversion result
   output logic [WORD-1:0] o_conv_result,
   output logic o_conv_wr
);
   logic above_reg, above_next;
   logic match_reg, match_next;
   logic below_reg, below_next;
   logic fault_reg, fault_next;
   logic wr_reg, wr_next;
   logic [WORD-1:0] result_reg, result_next;
   logic [WORD-1:0] decimal_to_radix2_convert;
   logic bad_digit;
   logic signed [2*WORD-1:0] a, b;
   scbc_pkg::scbc_op_t op;

   scbc_bcd_conv #(.DIGITS(WORD/4)) u_conv (
      .i_bcd(i_conv_src),
      .o_bin(decimal_to_radix2_convert),
      .o_bad_digit(bad_digit)
   );

   // high word above low word
   assign a = {i_first_operand_hi, i_first_operand_lo};
   assign b = {i_second_operand_hi, i_second_operand_lo};

   always_comb begin
      if (i_cmp_cond) begin
         op = scbc_pkg::SCBC_OP_CMP;
      end else if (i_conv_cond) begin
         op = scbc_pkg::SCBC_OP_CONV;
      end else begin
         op = scbc_pkg::SCBC_OP_NONE;
      end
   end

   always_comb begin
      above_next = above_reg;
      match_next = match_reg;
      below_next = below_reg;
      fault_next = fault_reg;
      result_next = result_reg;
      wr_next = 1'b0;
      unique case (op)
         scbc_pkg::SCBC_OP_NONE: begin
            above_next = above_reg;
            result_next = result_reg;
         end
         scbc_pkg::SCBC_OP_CMP: begin
            fault_next = i_operand_missing;
            if (!i_operand_missing) begin
               above_next = a > b;
               below_next = a < b;
               match_next = a == b;
            end
         end
         scbc_pkg::SCBC_OP_CONV: begin
            fault_next = i_operand_missing | bad_digit;
            if (!i_operand_missing && !bad_digit) begin
               result_next = decimal_to_radix2_convert;
               wr_next = 1'b1;
               match_next = decimal_to_radix2_convert == '0;
            end
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         above_reg <= `SCBC_FLAG_RST;
         match_reg <= `SCBC_FLAG_RST;
         below_reg <= `SCBC_FLAG_RST;
         fault_reg <= `SCBC_FLAG_RST;
         wr_reg <= 1'b0;
         result_reg <= `SCBC_RESULT_RST;
      end else begin
         above_reg <= above_next;
         match_reg <= match_next;
         below_reg <= below_next;
         fault_reg <= fault_next;
         wr_reg <= wr_next;
         result_reg <= result_next;
      end
   end

   // relay bits 25505, 25506, 25507
   assign o_above_flag = above_reg;
   assign o_match_flag = match_reg;
   assign o_below_flag = below_reg;
   assign o_fault_flag = fault_reg;
   assign o_conv_result = result_reg;
   assign o_conv_wr = wr_reg;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   cmp_greater_a: assert property (i_cmp_cond && !i_operand_missing && a > b
      |=> o_above_flag && !o_match_flag && !o_below_flag)
      else $error("above flag wrong");
   cmp_less_a: assert property (i_cmp_cond && !i_operand_missing && a < b
      |=> o_below_flag && !o_match_flag && !o_above_flag)
      else $error("below flag wrong");
   cmp_equal_a: assert property (i_cmp_cond && !i_operand_missing && a == b
      |=> o_match_flag && !o_above_flag && !o_below_flag)
      else $error("match flag wrong");
   cmp_signed_a: assert property (i_cmp_cond && !i_operand_missing
      && a[2*WORD-1] && !b[2*WORD-1] |=> o_below_flag)
      else $error("sign ignored");
   idle_hold_a: assert property (!i_cmp_cond && !i_conv_cond
      |=> $stable(o_above_flag) && $stable(o_below_flag)
      && $stable(o_match_flag) && $stable(o_conv_result))
      else $error("flags changed while idle");
   missing_fault_a: assert property ((i_cmp_cond || i_conv_cond)
      && i_operand_missing |=> o_fault_flag)
      else $error("missing operand not flagged");
   conv_value_a: assert property (!i_cmp_cond && i_conv_cond
      && !i_operand_missing && !bad_digit |=> o_conv_wr
      && o_conv_result == $past(decimal_to_radix2_convert))
      else $error("conversion wrong");
   bad_digit_a: assert property (!i_cmp_cond && i_conv_cond && bad_digit
      |=> o_fault_flag && !o_conv_wr && $stable(o_conv_result))
      else $error("bad digit not refused");
   conv_zero_a: assert property (!i_cmp_cond && i_conv_cond
      && !i_operand_missing && i_conv_src == '0 |=> o_match_flag)
      else $error("zero not flagged");
   conv_only_a: assert property (o_conv_wr |-> $past(i_conv_cond)
      && !$past(i_cmp_cond))
      else $error("stray write");

   // missing operand leaves compare flags
   property cmp_missing_keep_p;
      i_cmp_cond && i_operand_missing
      |=> $stable(o_above_flag) && $stable(o_match_flag)
      && $stable(o_below_flag);
   endproperty
   cmp_missing_keep_a: assert property (cmp_missing_keep_p)
      else $error("flags moved on missing operand");

   // good compare clears fault
   property cmp_fault_clear_p;
      i_cmp_cond && !i_operand_missing
      |=> !o_fault_flag;
   endproperty
   cmp_fault_clear_a: assert property (cmp_fault_clear_p)
      else $error("fault left after good compare");

   // missing operand blocks the write
   property conv_missing_keep_p;
      !i_cmp_cond && i_conv_cond && i_operand_missing
      |=> o_fault_flag && !o_conv_wr && $stable(o_conv_result)
      && $stable(o_match_flag);
   endproperty
   conv_missing_keep_a: assert property (conv_missing_keep_p)
      else $error("write despite missing operand");

   // nonzero source clears match
   property conv_nonzero_p;
      !i_cmp_cond && i_conv_cond && !i_operand_missing && !bad_digit
      && i_conv_src != '0
      |=> !o_match_flag;
   endproperty
   conv_nonzero_a: assert property (conv_nonzero_p)
      else $error("match set on nonzero result");

   // conversion leaves above and below
   property conv_keeps_cmp_p;
      !i_cmp_cond && i_conv_cond
      |=> $stable(o_above_flag) && $stable(o_below_flag);
   endproperty
   conv_keeps_cmp_a: assert property (conv_keeps_cmp_p)
      else $error("conversion touched compare flags");

   // compare never writes the result
   property cmp_no_write_p;
      i_cmp_cond
      |=> !o_conv_wr && $stable(o_conv_result);
   endproperty
   cmp_no_write_a: assert property (cmp_no_write_p)
      else $error("compare wrote the result");

   // exactly one compare flag
   property cmp_onehot_p;
      i_cmp_cond && !i_operand_missing
      |=> $onehot({o_above_flag, o_match_flag, o_below_flag});
   endproperty
   cmp_onehot_a: assert property (cmp_onehot_p)
      else $error("compare flags not one-hot");

   // idle cycle writes nothing
   property idle_no_write_p;
      !i_cmp_cond && !i_conv_cond
      |=> !o_conv_wr && $stable(o_fault_flag);
   endproperty
   idle_no_write_a: assert property (idle_no_write_p)
      else $error("write or fault change while idle");

   // bad digit keeps every flag but fault
   property bad_flags_keep_p;
      !i_cmp_cond && i_conv_cond && bad_digit
      |=> $stable(o_match_flag) && $stable(o_above_flag)
      && $stable(o_below_flag);
   endproperty
   bad_flags_keep_a: assert property (bad_flags_keep_p)
      else $error("flags moved on bad digit");

   // positive beats negative
   property cmp_signed_pos_p;
      i_cmp_cond && !i_operand_missing
      && !a[2*WORD-1] && b[2*WORD-1]
      |=> o_above_flag;
   endproperty
   cmp_signed_pos_a: assert property (cmp_signed_pos_p)
      else $error("sign ignored for positive first");

   // low word decides on equal high words
   property word_order_p;
      i_cmp_cond && !i_operand_missing
      && i_first_operand_hi == i_second_operand_hi
      && i_first_operand_lo > i_second_operand_lo
      |=> o_above_flag;
   endproperty
   word_order_a: assert property (word_order_p)
      else $error("low word compared wrongly");

   // high word dominates
   property hi_dominates_p;
      i_cmp_cond && !i_operand_missing
      && $signed(i_first_operand_hi) < $signed(i_second_operand_hi)
      |=> o_below_flag;
   endproperty
   hi_dominates_a: assert property (hi_dominates_p)
      else $error("high word not dominant");

   // single units digit
   property conv_units_p;
      !i_cmp_cond && i_conv_cond && !i_operand_missing
      && i_conv_src[WORD-1:4] == '0 && i_conv_src[3:0] <= 4'h9
      |=> o_conv_result == WORD'($past(i_conv_src[3:0]));
   endproperty
   conv_units_a: assert property (conv_units_p)
      else $error("units digit converted wrongly");

   // zero source gives zero result
   property conv_zero_result_p;
      !i_cmp_cond && i_conv_cond && !i_operand_missing
      && i_conv_src == '0
      |=> o_conv_wr && o_conv_result == '0;
   endproperty
   conv_zero_result_a: assert property (conv_zero_result_p)
      else $error("zero source not written as zero");

   // write only without fault
   property wr_no_fault_p;
      o_conv_wr |-> !o_fault_flag;
   endproperty
   wr_no_fault_a: assert property (wr_no_fault_p)
      else $error("write together with fault");

   // fault rises only on an executed op
   property fault_exec_p;
      $rose(o_fault_flag) |-> $past(i_cmp_cond || i_conv_cond);
   endproperty
   fault_exec_a: assert property (fault_exec_p)
      else $error("fault raised while idle");

   // reset clears all outputs
   property reset_clear_p;
      disable iff (1'b0)
      i_rst |=> !o_above_flag && !o_match_flag && !o_below_flag
      && !o_fault_flag && !o_conv_wr && o_conv_result == '0;
   endproperty
   reset_clear_a: assert property (reset_clear_p)
      else $error("outputs not cleared by reset");

   greater_c: cover property (i_cmp_cond ##1 o_above_flag);
   less_c: cover property (i_cmp_cond ##1 o_below_flag);
   conv_c: cover property (o_conv_wr && o_match_flag);
   fault_c: cover property (i_conv_cond && bad_digit ##1 o_fault_flag);
   missing_c: cover property (i_cmp_cond && i_operand_missing
      ##1 o_fault_flag);
endmodule // scbc_top
